// *** verification/excseq_asserts.sv ***
// concurrent checks on the exception sequencer ports
`default_nettype none
module excseq_asserts
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic exc_req,
    input wire excseq_pkg::excseq_kind_t exc_kind,
    input wire logic [2:0] irq_level,
    input wire logic [15:0] cur_sr,
    input wire logic halt_req,
    input wire logic exc_busy,
    input wire logic exc_done,
    input wire logic [15:0] new_sr,
    input wire logic [15:0] saved_sr,
    input wire logic bus_req,
    input wire logic bus_write,
    input wire logic bus_iack,
    input wire logic [2:0] bus_fc,
    input wire logic [31:0] bus_addr,
    input wire logic bus_ack,
    input wire logic pipe_refill
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************
    // snapshot and properties
    // ****************
    logic [15:0] snap_reg;
    logic [15:0] snap_next;
    // freezes once busy rises, so it holds what stood at the take edge
    always_comb snap_next = exc_busy ? snap_reg : cur_sr;
    always_ff @(posedge sys_clk or negedge resetn)
        if (!resetn)
            snap_reg <= 16'h0000;
        else
            snap_reg <= snap_next;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    a_busy_cause: assert property ($rose(exc_busy) |-> $past(exc_req) && !$past(halt_req))
        else $error("busy without request");
    a_super_set: assert property ($rose(exc_busy) |-> ##[1:3] new_sr[15:13] == 3'h1)
        else $error("supervisor or trace wrong");
    a_snap_kept: assert property (exc_done |-> saved_sr == snap_reg)
        else $error("stacked status not snapshot");
    a_mask_kept: assert property (exc_done && exc_kind[1] |-> new_sr[10:8] == snap_reg[10:8])
        else $error("mask changed");
    a_mask_irq: assert property (exc_done && exc_kind == excseq_pkg::EXCSEQ_KIND_IRQ
        |-> new_sr[10:8] == irq_level)
        else $error("irq mask wrong");
    a_iack_read: assert property (bus_req && bus_iack |-> !bus_write && bus_fc == 3'h7
        && exc_kind == excseq_pkg::EXCSEQ_KIND_IRQ)
        else $error("bad iack cycle");
    a_write_fc: assert property (bus_req && bus_write |-> bus_fc == 3'h5
        && exc_kind != excseq_pkg::EXCSEQ_KIND_RESET)
        else $error("bad frame write");
    a_req_held: assert property (bus_req && !bus_ack |=> bus_req && $stable(bus_addr))
        else $error("request dropped");
    a_refill_done: assert property (pipe_refill |=> exc_done)
        else $error("refill not followed by done");
endmodule : excseq_asserts
bind excseq_top excseq_asserts u_excseq_asserts (.sys_clk, .resetn, .exc_req, .exc_kind,
    .irq_level, .cur_sr, .halt_req, .exc_busy, .exc_done, .new_sr, .saved_sr, .bus_req,
    .bus_write, .bus_iack, .bus_fc, .bus_addr, .bus_ack, .pipe_refill);
`default_nettype wire

// *** verification/excseq_bus_model.sv ***
// system bus responder with interrupt acknowledge answer
`default_nettype none
module excseq_bus_model
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic bus_req,
    input wire logic bus_write,
    input wire logic bus_iack,
    input wire logic [31:0] bus_addr,
    input wire logic slow,
    input wire logic use_auto_vector_request,
    input wire logic [7:0] iack_vec,
    output logic bus_ack,
    output logic [31:0] bus_rdata,
    output logic auto_vector_request
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************
    // responder
    // ****************
    logic [1:0] wait_reg;
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            bus_ack <= 1'b0;
            wait_reg <= 2'h0;
            bus_rdata <= 32'h0;
            auto_vector_request <= 1'b0;
        end
        else
        begin
            bus_ack <= 1'b0;
            auto_vector_request <= 1'b0;
            // released data toggles so a stale word is never mistaken for an answer
            bus_rdata <= ~bus_rdata;
            if (bus_req && !bus_ack)
            begin
                if (slow && wait_reg != 2'h3)
                    wait_reg <= wait_reg + 2'h1;
                else
                begin
                    wait_reg <= 2'h0;
                    bus_ack <= 1'b1;
                    if (bus_iack)
                    begin
                        bus_rdata <= {24'h0, iack_vec};
                        auto_vector_request <= use_auto_vector_request;
                    end
                    else if (!bus_write)
                        bus_rdata <= bus_addr ^ 32'h5A5A0000;
                end
            end
        end
    end
endmodule : excseq_bus_model
`default_nettype wire

// *** verification/tb_top.sv ***
// self-checking bench for the exception sequencer
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************
    // bench
    // ****************
    typedef struct {
        logic [15:0] sr, ss;
        logic [31:0] va, low, nwr;
        logic [7:0] vec;
        logic ia, cl;
    } excseq_exp_t;
    logic sys_clk = 1'b0, resetn = 1'b0, exc_req = 1'b0, halt_req = 1'b0, avs_read = 1'b0;
    logic avs_write = 1'b0, slow = 1'b0, use_auto_vector_request = 1'b0, seen_ia = 1'b0;
    excseq_pkg::excseq_kind_t exc_kind = excseq_pkg::EXCSEQ_KIND_RESET;
    logic [7:0] exc_int_vector = 8'h00, copro_vector = 8'h00, iack_vec = 8'h00;
    logic [2:0] irq_level = 3'h0;
    logic [3:0] frame_words = 4'h4, avs_byteenable = 4'hF;
    logic [1:0] avs_address = 2'h0, seq_status;
    logic [15:0] cur_sr = 16'h0000, new_sr, saved_sr;
    logic [31:0] cur_pc = 32'h0, isp_in = 32'h0, msp_in = 32'h0, vector_base_register = 32'h0;
    logic [31:0] avs_writedata = 32'h0, rs = 32'hD, seen_va = 32'h0, seen_low = 32'hFFFFFFFF;
    logic [31:0] seen_wr = 32'h0, new_pc, bus_addr, bus_rdata, avs_readdata, d0, d1;
    logic exc_busy, exc_done, bus_req, bus_write, bus_iack, bus_ack, auto_vector_request;
    logic avs_waitrequest;
    int err_total = 0, n_checks = 0;
    excseq_exp_t exp_q[$];
    excseq_exp_t got;
    excseq_top u_excseq_top (.sys_clk, .resetn, .exc_req, .exc_kind, .exc_int_vector,
        .copro_vector, .irq_level, .frame_words, .cur_pc, .cur_sr, .isp_in, .msp_in,
        .vector_base_register, .exc_busy, .exc_done, .new_sr, .new_pc, .new_isp(), .new_msp(),
        .saved_sr, .bus_req, .bus_write, .bus_iack, .bus_fc(), .bus_addr, .bus_wdata(), .bus_ack,
        .bus_rdata, .auto_vector_request, .seq_status, .pipe_refill(), .halt_req, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest);
    excseq_bus_model u_excseq_bus_model (.sys_clk, .resetn, .bus_req, .bus_write, .bus_iack,
        .bus_addr, .slow, .use_auto_vector_request, .iack_vec, .bus_ack, .bus_rdata, .auto_vector_request);
    initial
    begin
        forever #20 sys_clk = ~sys_clk;
    end
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction : rnd
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    task automatic av_rw(input logic w, input logic [1:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= rnd();
        avs_write <= w;
        avs_read <= !w;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : av_rw
    task automatic run_exc(input logic [1:0] k);
        excseq_exp_t e;
        logic [31:0] r, sp_i, sp_m, vb;
        logic [3:0] fw;
        r = rnd();
        sp_i = rnd() & 32'h00FFFFF0;
        sp_m = rnd() & 32'h00FFFFF0;
        vb = rnd() & 32'h00FFFC00;
        fw = k[1] ? 4'h4 + (r[11:8] % 4'h9) : 4'h4;
        e.ss = r[31:16];
        e.sr = {3'h1, e.ss[12:0]};
        if (!k[1])
            e.sr[12:8] = {2'h0, (k == 2'h0) ? 3'h7 : r[2:0]};
        e.sr[11] = e.ss[11];
        case (k)
            2'h0: e.vec = 8'h00;
            2'h1: e.vec = r[3] ? 8'h18 + {5'h0, r[2:0]} : r[15:8];
            2'h2: e.vec = r[31:24];
            default: e.vec = r[23:16];
        endcase
        e.va = vb + {22'h0, e.vec, 2'h0};
        e.nwr = (k == 2'h0) ? 32'h0 : {28'h0, fw} + ((k == 2'h1 && e.ss[12]) ? 32'h4 : 32'h0);
        e.ia = (k == 2'h1);
        e.cl = !(k == 2'h1 && e.ss[12]);
        e.low = (k == 2'h0) ? 32'hFFFFFFFF : ((k[1] && e.ss[12]) ? sp_m : sp_i) - {fw, 2'h0};
        exp_q.push_back(e);
        exc_kind <= excseq_pkg::excseq_kind_t'(k);
        irq_level <= r[2:0];
        use_auto_vector_request <= r[3];
        slow <= r[4];
        iack_vec <= r[15:8];
        copro_vector <= r[31:24];
        exc_int_vector <= r[23:16];
        frame_words <= fw;
        cur_sr <= e.ss;
        cur_pc <= rnd();
        isp_in <= sp_i;
        msp_in <= sp_m;
        vector_base_register <= vb;
        exc_req <= 1'b1;
        do @(posedge sys_clk); while (exc_busy !== 1'b1);
        exc_req <= 1'b0;
        do @(posedge sys_clk); while (exc_done !== 1'b1);
        av_rw(1'b0, 2'h1, d0);
        chk("vector word", {24'h0, e.vec}, d0);
        av_rw(1'b0, 2'h0, d0);
        chk("status word", {6'h0, 2'h1, 8'h0, e.sr}, {d0[31:24], 8'h0, d0[15:0]});
    endtask : run_exc
    always @(posedge sys_clk)
    begin
        if (bus_req === 1'b1 && bus_ack === 1'b1)
        begin
            if (bus_write === 1'b1)
            begin
                seen_wr++;
                seen_low = (bus_addr < seen_low) ? bus_addr : seen_low;
            end
            else if (bus_iack === 1'b1)
                seen_ia = 1'b1;
            else
                seen_va = bus_addr;
        end
        if (exc_done === 1'b1 && exp_q.size() > 0)
        begin
            got = exp_q.pop_front();
            chk("vector address", got.va, seen_va);
            chk("new pc", got.va ^ 32'h5A5A0000, new_pc);
            chk("saved sr", {16'h0, got.ss}, {16'h0, saved_sr});
            chk("new sr", {16'h0, got.sr}, {16'h0, new_sr});
            chk("frame writes", got.nwr, seen_wr);
            chk("iack cycle", {31'h0, got.ia}, {31'h0, seen_ia});
            if (got.cl)
                chk("frame bottom", got.low, seen_low);
            seen_wr = 32'h0;
            seen_ia = 1'b0;
            seen_low = 32'hFFFFFFFF;
        end
    end
    initial
    begin
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        for (int i = 0; i < 16; i++)
            run_exc(2'(i));
        halt_req <= 1'b1;
        exc_req <= 1'b1;
        repeat (6) @(posedge sys_clk);
        chk("busy while halted", 32'h0, {31'h0, exc_busy});
        chk("halted status", 32'h3, {30'h0, seq_status});
        halt_req <= 1'b0;
        exc_req <= 1'b0;
        av_rw(1'b0, 2'h1, d0);
        av_rw(1'b1, 2'h1, d1);
        av_rw(1'b0, 2'h1, d1);
        chk("ignored write", d0, d1);
        av_rw(1'b0, 2'h3, d1);
        chk("unused word", 32'h0, d1);
        report_and_stop();
    end
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire

// *** verilog/excseq_consts.svh ***
// constants for the exception sequencer
`ifndef EXCSEQ_CONSTS_SVH
`define EXCSEQ_CONSTS_SVH
// ****************************************
// status register layout
// ****************************************
`define EXCSEQ_SR_TRACE_HI 15
`define EXCSEQ_SR_TRACE_LO 14
`define EXCSEQ_SR_S 13
`define EXCSEQ_SR_M 12
`define EXCSEQ_SR_IPM_HI 10
`define EXCSEQ_SR_IPM_LO 8
`define EXCSEQ_SR_RESET 16'h2700
// ****************************************
// vectors and frames
// ****************************************
`define EXCSEQ_VEC_RESET 8'h00
`define EXCSEQ_VEC_AUTO_BASE 8'h18
`define EXCSEQ_VEC_SPURIOUS 8'h18
`define EXCSEQ_SHORT_FRAME_WORDS 4'h4
`define EXCSEQ_FC_CPU_SPACE 3'h7
`define EXCSEQ_FC_SUPER_DATA 3'h5
`define EXCSEQ_IACK_ADDR_BASE 32'hFFFFFFF1
`endif

// *** verilog/excseq_pkg.sv ***
// types for the exception sequencer
`default_nettype none
package excseq_pkg;
    typedef enum logic [1:0] {
        EXCSEQ_KIND_RESET = 2'h0,
        EXCSEQ_KIND_IRQ = 2'h1,
        EXCSEQ_KIND_COPRO = 2'h2,
        EXCSEQ_KIND_INTERNAL = 2'h3
    } excseq_kind_t;
    typedef enum logic [9:0] {
        EXCSEQ_ST_IDLE = 10'h001,
        EXCSEQ_ST_STATUS = 10'h002,
        EXCSEQ_ST_VECNUM = 10'h004,
        EXCSEQ_ST_IACK = 10'h008,
        EXCSEQ_ST_SAVE = 10'h010,
        EXCSEQ_ST_COPY = 10'h020,
        EXCSEQ_ST_VADDR = 10'h040,
        EXCSEQ_ST_VFETCH = 10'h080,
        EXCSEQ_ST_REFILL = 10'h100,
        EXCSEQ_ST_HALT = 10'h200
    } excseq_state_t;
    typedef enum logic [1:0] {
        EXCSEQ_STAT_RUN = 2'h0,
        EXCSEQ_STAT_BOUNDARY = 2'h1,
        EXCSEQ_STAT_EXCEPTION = 2'h2,
        EXCSEQ_STAT_HALTED = 2'h3
    } excseq_status_t;
endpackage : excseq_pkg
`default_nettype wire

// *** verilog/excseq_top.sv ***
// exception processing sequencer with bus master port and avalon status slave
`include "excseq_consts.svh"
`default_nettype none
module excseq_top
(
    input wire logic sys_clk,
    input wire logic resetn,
    // request from the integer pipeline
    input wire logic exc_req,
    input wire excseq_pkg::excseq_kind_t exc_kind,
    input wire logic [7:0] exc_int_vector,
    input wire logic [7:0] copro_vector,
    input wire logic [2:0] irq_level,
    input wire logic [3:0] frame_words,
    input wire logic [31:0] cur_pc,
    input wire logic [15:0] cur_sr,
    input wire logic [31:0] isp_in,
    input wire logic [31:0] msp_in,
    input wire logic [31:0] vector_base_register,
    output logic exc_busy,
    output logic exc_done,
    // register file updates
    output logic [15:0] new_sr,
    output logic [31:0] new_pc,
    output logic [31:0] new_isp,
    output logic [31:0] new_msp,
    output logic [15:0] saved_sr,
    // simple bus master, one word per request
    output logic bus_req,
    output logic bus_write,
    output logic bus_iack,
    output logic [2:0] bus_fc,
    output logic [31:0] bus_addr,
    output logic [31:0] bus_wdata,
    input wire logic bus_ack,
    input wire logic [31:0] bus_rdata,
    input wire logic auto_vector_request,
    // emulation outputs
    output logic [1:0] seq_status,
    output logic pipe_refill,
    input wire logic halt_req,
    // avalon-mm status slave
    input wire logic [1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    // ****************************************
    // sequencer state
    // ****************************************
    excseq_pkg::excseq_state_t state_reg, state_next;
    excseq_pkg::excseq_kind_t kind_reg, kind_next;
    logic [15:0] snap_reg, snap_next;
    logic [15:0] sr_reg, sr_next;
    logic [7:0] vec_reg, vec_next;
    logic [31:0] sp_reg, sp_next;
    logic [31:0] msp_reg, msp_next;
    logic [31:0] pc_reg, pc_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [3:0] words_reg, words_next;
    logic [2:0] lvl_reg, lvl_next;
    logic use_msp_reg, use_msp_next;
    logic busy_reg, busy_next;
    logic done_reg, done_next;
    logic [31:0] addr_reg, addr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [1:0] status_reg, status_next;
    logic refill_reg, refill_next;
    logic [7:0] exc_count_reg, exc_count_next;
    logic [31:0] frame_word;

    // frame contents: word 0 status snapshot, then pc, then format/vector word
    always_comb
    begin
        case (cnt_reg)
            4'h0: frame_word = {16'h0000, snap_reg};
            4'h1: frame_word = {16'h0000, pc_reg[31:16]};
            4'h2: frame_word = {16'h0000, pc_reg[15:0]};
            default: frame_word = {20'h00000, vec_reg, 2'h0, 2'h0};
        endcase
    end

    always_comb
    begin
        state_next = state_reg;
        kind_next = kind_reg;
        snap_next = snap_reg;
        sr_next = sr_reg;
        vec_next = vec_reg;
        sp_next = sp_reg;
        msp_next = msp_reg;
        pc_next = pc_reg;
        cnt_next = cnt_reg;
        words_next = words_reg;
        lvl_next = lvl_reg;
        use_msp_next = use_msp_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        exc_count_next = exc_count_reg;
        case (state_reg)
            excseq_pkg::EXCSEQ_ST_IDLE:
            begin
                if (halt_req)
                begin
                    state_next = excseq_pkg::EXCSEQ_ST_HALT;
                end
                else if (exc_req)
                begin
                    kind_next = exc_kind;
                    snap_next = cur_sr;
                    sr_next = cur_sr;
                    pc_next = cur_pc;
                    lvl_next = irq_level;
                    words_next = (frame_words < `EXCSEQ_SHORT_FRAME_WORDS) ?
                        `EXCSEQ_SHORT_FRAME_WORDS : frame_words;
                    msp_next = msp_in;
                    busy_next = 1'b1;
                    exc_count_next = exc_count_reg + 8'h01;
                    state_next = excseq_pkg::EXCSEQ_ST_STATUS;
                end
            end
            excseq_pkg::EXCSEQ_ST_STATUS:
            begin
                sr_next[`EXCSEQ_SR_S] = 1'b1;
                sr_next[`EXCSEQ_SR_TRACE_HI] = 1'b0;
                sr_next[`EXCSEQ_SR_TRACE_LO] = 1'b0;
                if (kind_reg == excseq_pkg::EXCSEQ_KIND_RESET)
                begin
                    sr_next[`EXCSEQ_SR_IPM_HI:`EXCSEQ_SR_IPM_LO] = 3'h7;
                    sr_next[`EXCSEQ_SR_M] = 1'b0;
                end
                else if (kind_reg == excseq_pkg::EXCSEQ_KIND_IRQ)
                begin
                    sr_next[`EXCSEQ_SR_IPM_HI:`EXCSEQ_SR_IPM_LO] = lvl_reg;
                end
                state_next = excseq_pkg::EXCSEQ_ST_VECNUM;
            end
            excseq_pkg::EXCSEQ_ST_VECNUM:
            begin
                case (kind_reg)
                    excseq_pkg::EXCSEQ_KIND_IRQ:
                    begin
                        addr_next = `EXCSEQ_IACK_ADDR_BASE | {28'h0000000, lvl_reg, 1'b0};
                        state_next = excseq_pkg::EXCSEQ_ST_IACK;
                    end
                    excseq_pkg::EXCSEQ_KIND_COPRO:
                    begin
                        vec_next = copro_vector;
                        state_next = excseq_pkg::EXCSEQ_ST_SAVE;
                    end
                    excseq_pkg::EXCSEQ_KIND_RESET:
                    begin
                        vec_next = `EXCSEQ_VEC_RESET;
                        state_next = excseq_pkg::EXCSEQ_ST_VADDR;
                    end
                    default:
                    begin
                        vec_next = exc_int_vector;
                        state_next = excseq_pkg::EXCSEQ_ST_SAVE;
                    end
                endcase
                // an interrupt with the master flag set still saves on the master stack
                // first; the short frame is copied to the interrupt stack afterwards
                if (sr_reg[`EXCSEQ_SR_M])
                begin
                    use_msp_next = 1'b1;
                    sp_next = msp_reg;
                end
                else
                begin
                    use_msp_next = 1'b0;
                    sp_next = isp_in;
                end
                cnt_next = 4'h0;
            end
            excseq_pkg::EXCSEQ_ST_IACK:
            begin
                if (bus_ack)
                begin
                    if (auto_vector_request)
                    begin
                        vec_next = `EXCSEQ_VEC_AUTO_BASE + {5'h00, lvl_reg};
                    end
                    else
                    begin
                        vec_next = bus_rdata[7:0];
                    end
                    state_next = excseq_pkg::EXCSEQ_ST_SAVE;
                end
            end
            excseq_pkg::EXCSEQ_ST_SAVE:
            begin
                // the bus request is held until ack, one frame word each
                sp_next = sp_reg - 32'h00000004;
                addr_next = sp_reg - 32'h00000004;
                wdata_next = frame_word;
                if (bus_ack)
                begin
                    if (cnt_reg == words_reg - 4'h1)
                    begin
                        cnt_next = 4'h0;
                        if (kind_reg == excseq_pkg::EXCSEQ_KIND_IRQ && sr_reg[`EXCSEQ_SR_M])
                        begin
                            sr_next[`EXCSEQ_SR_M] = 1'b0;
                            sp_next = isp_in;
                            state_next = excseq_pkg::EXCSEQ_ST_COPY;
                        end
                        else
                        begin
                            state_next = excseq_pkg::EXCSEQ_ST_VADDR;
                        end
                    end
                    else
                    begin
                        cnt_next = cnt_reg + 4'h1;
                    end
                end
                else
                begin
                    sp_next = sp_reg;
                end
            end
            excseq_pkg::EXCSEQ_ST_COPY:
            begin
                addr_next = sp_reg - 32'h00000004;
                wdata_next = frame_word;
                if (bus_ack)
                begin
                    sp_next = sp_reg - 32'h00000004;
                    if (cnt_reg == `EXCSEQ_SHORT_FRAME_WORDS - 4'h1)
                    begin
                        state_next = excseq_pkg::EXCSEQ_ST_VADDR;
                    end
                    else
                    begin
                        cnt_next = cnt_reg + 4'h1;
                    end
                end
            end
            excseq_pkg::EXCSEQ_ST_VADDR:
            begin
                if (kind_reg == excseq_pkg::EXCSEQ_KIND_IRQ)
                begin
                    sr_next[`EXCSEQ_SR_M] = 1'b0;
                end
                addr_next = vector_base_register + {22'h000000, vec_reg, 2'b00};
                state_next = excseq_pkg::EXCSEQ_ST_VFETCH;
            end
            excseq_pkg::EXCSEQ_ST_VFETCH:
            begin
                if (bus_ack)
                begin
                    pc_next = bus_rdata;
                    state_next = excseq_pkg::EXCSEQ_ST_REFILL;
                end
            end
            excseq_pkg::EXCSEQ_ST_REFILL:
            begin
                busy_next = 1'b0;
                done_next = 1'b1;
                state_next = excseq_pkg::EXCSEQ_ST_IDLE;
            end
            excseq_pkg::EXCSEQ_ST_HALT:
            begin
                if (!halt_req)
                begin
                    state_next = excseq_pkg::EXCSEQ_ST_IDLE;
                end
            end
            default:
            begin
                state_next = excseq_pkg::EXCSEQ_ST_IDLE;
            end
        endcase
    end

    // activity outputs decoded from the next state only, never from bus signals
    always_comb
    begin
        refill_next = (state_next == excseq_pkg::EXCSEQ_ST_REFILL);
        case (state_next)
            excseq_pkg::EXCSEQ_ST_HALT: status_next = excseq_pkg::EXCSEQ_STAT_HALTED;
            excseq_pkg::EXCSEQ_ST_IDLE: status_next = excseq_pkg::EXCSEQ_STAT_BOUNDARY;
            excseq_pkg::EXCSEQ_ST_REFILL: status_next = excseq_pkg::EXCSEQ_STAT_RUN;
            default: status_next = excseq_pkg::EXCSEQ_STAT_EXCEPTION;
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg <= excseq_pkg::EXCSEQ_ST_IDLE;
            kind_reg <= excseq_pkg::EXCSEQ_KIND_RESET;
            snap_reg <= `EXCSEQ_SR_RESET;
            sr_reg <= `EXCSEQ_SR_RESET;
            vec_reg <= 8'h00;
            sp_reg <= 32'h00000000;
            msp_reg <= 32'h00000000;
            pc_reg <= 32'h00000000;
            cnt_reg <= 4'h0;
            words_reg <= `EXCSEQ_SHORT_FRAME_WORDS;
            lvl_reg <= 3'h0;
            use_msp_reg <= 1'b0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            addr_reg <= 32'h00000000;
            wdata_reg <= 32'h00000000;
            status_reg <= 2'h1;
            refill_reg <= 1'b0;
            exc_count_reg <= 8'h00;
        end
        else
        begin
            state_reg <= state_next;
            kind_reg <= kind_next;
            snap_reg <= snap_next;
            sr_reg <= sr_next;
            vec_reg <= vec_next;
            sp_reg <= sp_next;
            msp_reg <= msp_next;
            pc_reg <= pc_next;
            cnt_reg <= cnt_next;
            words_reg <= words_next;
            lvl_reg <= lvl_next;
            use_msp_reg <= use_msp_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            status_reg <= status_next;
            refill_reg <= refill_next;
            exc_count_reg <= exc_count_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    always_comb
    begin
        bus_req = (state_reg == excseq_pkg::EXCSEQ_ST_IACK) ||
            (state_reg == excseq_pkg::EXCSEQ_ST_SAVE && addr_reg == sp_reg - 32'h00000004) ||
            (state_reg == excseq_pkg::EXCSEQ_ST_COPY && addr_reg == sp_reg - 32'h00000004) ||
            (state_reg == excseq_pkg::EXCSEQ_ST_VFETCH);
        bus_write = (state_reg == excseq_pkg::EXCSEQ_ST_SAVE) ||
            (state_reg == excseq_pkg::EXCSEQ_ST_COPY);
        bus_iack = (state_reg == excseq_pkg::EXCSEQ_ST_IACK);
        bus_fc = bus_iack ? `EXCSEQ_FC_CPU_SPACE : `EXCSEQ_FC_SUPER_DATA;
    end
    assign bus_addr = addr_reg;
    assign bus_wdata = wdata_reg;
    assign exc_busy = busy_reg;
    assign exc_done = done_reg;
    assign new_sr = sr_reg;
    assign new_pc = pc_reg;
    assign saved_sr = snap_reg;
    assign new_isp = use_msp_reg ? isp_in : sp_reg;
    assign new_msp = use_msp_reg ? sp_reg : msp_reg;
    assign seq_status = status_reg;
    assign pipe_refill = refill_reg;

    // ****************************************
    // avalon status slave, read-only, one wait cycle on reads
    // ****************************************
    logic [31:0] rdata_reg, rdata_next;
    always_comb
    begin
        case (avs_address)
            2'h0: rdata_next = {6'h00, status_reg, exc_count_reg, sr_reg};
            2'h1: rdata_next = {24'h000000, vec_reg};
            2'h2: rdata_next = pc_reg;
            default: rdata_next = 32'h00000000;
        endcase
        if (!avs_read)
        begin
            rdata_next = rdata_reg;
        end
    end
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdata_reg <= 32'h00000000;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end
    // one wait cycle on reads so the data comes from a flop; writes are ignored
    logic rd_pend_reg, rd_pend_next;
    always_comb
    begin
        rd_pend_next = avs_read && !rd_pend_reg;
    end
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rd_pend_reg <= 1'b0;
        end
        else
        begin
            rd_pend_reg <= rd_pend_next;
        end
    end
    assign avs_waitrequest = avs_read && !rd_pend_reg;
    assign avs_readdata = rdata_reg;
endmodule : excseq_top
`default_nettype wire
